// ---- hw/qrt_pkg.sv ----
// Constants shared by the quad reload timer unit.
package qrt_pkg;
  localparam int unsigned QRT_ADDR_W = 12;
  localparam int unsigned QRT_DATA_W = 32;
  // Register byte offsets.
  localparam logic [11:0] QRT_OFF_CLK_MODE    = 12'h000;
  localparam logic [11:0] QRT_OFF_FIXED_PRE   = 12'h004;
  localparam logic [11:0] QRT_OFF_FIXED_CNT   = 12'h008;
  localparam logic [11:0] QRT_OFF_MM_PRE      = 12'h00C;
  localparam logic [11:0] QRT_OFF_MM_CNT      = 12'h010;
  localparam logic [11:0] QRT_OFF_MM_MODE     = 12'h014;
  localparam logic [11:0] QRT_OFF_WIDE_A_LOW  = 12'h018;
  localparam logic [11:0] QRT_OFF_WIDE_A_HIGH = 12'h01C;
  localparam logic [11:0] QRT_OFF_WIDE_B_LOW  = 12'h020;
  localparam logic [11:0] QRT_OFF_WIDE_B_HIGH = 12'h024;
  localparam logic [11:0] QRT_OFF_SRC_SEL     = 12'h028;
  localparam logic [11:0] QRT_OFF_WIDE_CTRL   = 12'h02C;
  localparam logic [11:0] QRT_OFF_REQ_FLAGS   = 12'h030;
  // Clock mode field: bits 7 and 6 choose the divider source.
  localparam int unsigned QRT_CLK_DIV_LSB  = 6;
  localparam logic [1:0]  QRT_CLK_DIV_RING = 2'h2;
  // Multimode control fields.
  localparam int unsigned QRT_MM_MODE_LSB = 0;
  localparam int unsigned QRT_MM_POL_BIT  = 2;
  localparam int unsigned QRT_MM_STOP_BIT = 3;
  localparam int unsigned QRT_MM_INV_BIT  = 4;
  localparam int unsigned QRT_MM_SRC_LSB  = 5;
  // Count source select fields, three bits per wide counter.
  localparam int unsigned QRT_SRC_A_LSB = 0;
  localparam int unsigned QRT_SRC_B_LSB = 3;
  localparam logic [2:0]  QRT_SRC_ALT   = 3'h6;
  // Request flag positions.
  localparam int unsigned QRT_REQ_FIXED = 0;
  localparam int unsigned QRT_REQ_MM    = 1;
  localparam int unsigned QRT_REQ_WA    = 2;
  localparam int unsigned QRT_REQ_WB    = 3;
  localparam int unsigned QRT_REQ_EVT   = 4;
  localparam int unsigned QRT_REQ_W     = 5;
  // Reset values.
  localparam logic [7:0]  QRT_RST_BYTE = 8'h00;
  localparam logic [15:0] QRT_RST_WORD = 16'h0000;
  localparam logic [31:0] QRT_RST_DATA = 32'h0000_0000;
  // Divider taps: source divided by 2, 16, 32, 64, 128, 256.
  localparam int unsigned QRT_DIV_TAPS = 6;
  typedef enum logic [1:0] {
    QRT_MODE_TIMER = 2'b00,
    QRT_MODE_PULSE = 2'b01,
    QRT_MODE_EVENT = 2'b10,
    QRT_MODE_WIDTH = 2'b11
  } qrt_mode_t;
endpackage

// ---- hw/qrt_top.sv ----
// Quad reload timer unit with an APB register slave.
`timescale 1ns/1ps
// Functional notes
// - Each stage divides its count pulses by reload value plus one.
// - Counters count down; the pulse after zero underflows and reloads.
// - Every timer underflow sets that timer's request flag.
// - Divider takes the ring oscillator for selection 10, else the main one.
// - Fixed prescaler is 8 bits on source over sixteen; fixed timer 8 bits.
// - Writing an 8-bit prescaler or timer loads latch and counter together.
// - Reading an 8-bit prescaler or timer returns the live count.
// - The fixed timer always runs as a timer and cannot be stopped.
// - Each 8-bit timer counts its prescaler's underflows.
// - Multimode prescaler counts the source chosen by its select field, or pin edges in event mode.
// - Multimode timer offers timer, pulse, event and width modes.
// - Pulse mode toggles the event pin per underflow, start set by polarity.
// - Inverted output enable drives the complement on the secondary pin.
// - Event mode counts event pin edges of the chosen polarity.
// - Width mode counts the source only while the pin is at its level.
// - Stop bit halts the multimode counting in every mode.
// - Event request sets on falling edge for polarity 0, rising for 1.
// - Wide counters take a divider tap, or else the ring for A and the first underflow for B.
// - Wide counters underflow after zero, reload and set their flag.
// - Per-counter write control picks latch only or latch and counter.
module qrt_top
(
  // Clock and reset.
  input  wire logic                           clock,
  input  wire logic                           sys_rst,
  // APB slave.
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [qrt_pkg::QRT_ADDR_W-1:0] paddr,
  input  wire logic [qrt_pkg::QRT_DATA_W-1:0] pwdata,
  output logic      [qrt_pkg::QRT_DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Oscillator inputs.
  input  wire logic                           main_osc_input,
  input  wire logic                           ring_osc_input,
  // Event pin, split into its three signals, and the secondary pin.
  input  wire logic                           event_pin_in,
  output logic                                event_pin_out,
  output logic                                event_pin_oe_n,
  output logic                                inverted_pulse_pin,
  // Request flags.
  output logic [qrt_pkg::QRT_REQ_W-1:0]       req_flags
);
  import qrt_pkg::*;

  // Synchronisers: stage one, stage two, then a history stage for edges.
  logic [2:0] main_sync_reg;
  logic [2:0] ring_sync_reg;
  logic [2:0] evt_sync_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      main_sync_reg <= 3'h0;
      ring_sync_reg <= 3'h0;
      evt_sync_reg  <= 3'h0;
    end
    else
    begin
      main_sync_reg <= {main_sync_reg[1:0], main_osc_input};
      ring_sync_reg <= {ring_sync_reg[1:0], ring_osc_input};
      evt_sync_reg  <= {evt_sync_reg[1:0], event_pin_in};
    end
  end

  wire main_rise = main_sync_reg[1] & ~main_sync_reg[2];
  wire ring_rise = ring_sync_reg[1] & ~ring_sync_reg[2];
  wire evt_level = evt_sync_reg[1];
  wire evt_rise  = evt_sync_reg[1] & ~evt_sync_reg[2];
  wire evt_fall  = ~evt_sync_reg[1] & evt_sync_reg[2];

  // APB handshake: one wait state, answer on the second access cycle.
  // Side effects land only at the access edge where pready is high.
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic [QRT_DATA_W-1:0] prdata_reg;

  wire acc_first = psel & penable & ~pready_reg;
  wire acc_done  = psel & penable & pready_reg;
  wire wr_acc    = acc_done & pwrite;
  wire rd_acc    = acc_done & ~pwrite;
  wire [7:0] wbyte = pwdata[7:0];

  wire hit_clk   = paddr == QRT_OFF_CLK_MODE;
  wire hit_fpre  = paddr == QRT_OFF_FIXED_PRE;
  wire hit_fcnt  = paddr == QRT_OFF_FIXED_CNT;
  wire hit_mpre  = paddr == QRT_OFF_MM_PRE;
  wire hit_mcnt  = paddr == QRT_OFF_MM_CNT;
  wire hit_mode  = paddr == QRT_OFF_MM_MODE;
  wire hit_al    = paddr == QRT_OFF_WIDE_A_LOW;
  wire hit_ah    = paddr == QRT_OFF_WIDE_A_HIGH;
  wire hit_bl    = paddr == QRT_OFF_WIDE_B_LOW;
  wire hit_bh    = paddr == QRT_OFF_WIDE_B_HIGH;
  wire hit_src   = paddr == QRT_OFF_SRC_SEL;
  wire hit_wctl  = paddr == QRT_OFF_WIDE_CTRL;
  wire hit_flags = paddr == QRT_OFF_REQ_FLAGS;
  wire hit_any   = hit_clk | hit_fpre | hit_fcnt | hit_mpre | hit_mcnt
                 | hit_mode | hit_al | hit_ah | hit_bl | hit_bh
                 | hit_src | hit_wctl | hit_flags;

  // Control registers.
  logic [7:0] clk_mode_reg;
  logic [7:0] mm_mode_reg;
  logic [5:0] src_sel_reg;
  logic [1:0] wide_ctrl_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      clk_mode_reg  <= QRT_RST_BYTE;
      mm_mode_reg   <= QRT_RST_BYTE;
      src_sel_reg   <= 6'h00;
      wide_ctrl_reg <= 2'h0;
    end
    else if (wr_acc)
    begin
      if (hit_clk)
        clk_mode_reg <= wbyte;
      if (hit_mode)
        mm_mode_reg <= {1'b0, wbyte[6:0]};
      if (hit_src)
        src_sel_reg <= wbyte[5:0];
      if (hit_wctl)
        wide_ctrl_reg <= wbyte[1:0];
    end
  end

  wire [1:0] clk_div_sel = clk_mode_reg[QRT_CLK_DIV_LSB +: 2];
  wire [1:0] mm_mode     = mm_mode_reg[QRT_MM_MODE_LSB +: 2];
  wire       mm_pol      = mm_mode_reg[QRT_MM_POL_BIT];
  wire       mm_stop     = mm_mode_reg[QRT_MM_STOP_BIT];
  wire       mm_inv_en   = mm_mode_reg[QRT_MM_INV_BIT];
  wire [1:0] mm_src      = mm_mode_reg[QRT_MM_SRC_LSB +: 2];

  // Frequency divider shared by all count sources except the direct ring and A underflow selections.
  // Tap k above 0 fires on a source tick while the low k+3 count bits are all one; tap 0 uses bit 0 alone.
  wire src_tick = (clk_div_sel == QRT_CLK_DIV_RING) ? ring_rise
                                                    : main_rise;
  logic [7:0] div_cnt_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      div_cnt_reg <= QRT_RST_BYTE;
    else if (src_tick)
      div_cnt_reg <= div_cnt_reg + 8'h01;
  end

  wire [QRT_DIV_TAPS-1:0] div_tick = {&div_cnt_reg[7:0],
    &div_cnt_reg[6:0], &div_cnt_reg[5:0], &div_cnt_reg[4:0],
    &div_cnt_reg[3:0], div_cnt_reg[0]} & {QRT_DIV_TAPS{src_tick}};

  // Multimode prescaler source by select field.
  logic mm_src_tick;
  always_comb
  begin
    case (mm_src)
      2'b00:   mm_src_tick = div_tick[0];
      2'b01:   mm_src_tick = div_tick[1];
      2'b10:   mm_src_tick = div_tick[2];
      default: mm_src_tick = ring_rise;
    endcase
  end

  // Event mode counts pin edges; width mode gates the source by pin level.
  logic mm_in_tick;
  always_comb
  begin
    case (mm_mode)
      QRT_MODE_EVENT: mm_in_tick = mm_pol ? evt_fall : evt_rise;
      QRT_MODE_WIDTH: mm_in_tick = mm_src_tick
                                 & (evt_level == ~mm_pol);
      QRT_MODE_TIMER: mm_in_tick = mm_src_tick;
      QRT_MODE_PULSE: mm_in_tick = mm_src_tick;
      default:        mm_in_tick = 1'b0;
    endcase
  end

  // Four 8-bit reload stages: fixed pre, fixed timer, mm pre, mm timer.
  logic [7:0] cnt8_reg [4];
  logic [7:0] lat8_reg [4];
  wire  [3:0] en8;
  wire  [3:0] wr8;
  wire  [3:0] uf8;

  assign en8[0] = div_tick[1];
  assign en8[1] = uf8[0];
  assign en8[2] = mm_in_tick & ~mm_stop;
  assign en8[3] = uf8[2];
  assign wr8    = {hit_mcnt, hit_mpre, hit_fcnt, hit_fpre} & {4{wr_acc}};

  // A software write wins over a same-cycle count pulse, so no underflow.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_stage8
      assign uf8[gi] = en8[gi] & ~wr8[gi] & (cnt8_reg[gi] == 8'h00);
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          cnt8_reg[gi] <= QRT_RST_BYTE;
          lat8_reg[gi] <= QRT_RST_BYTE;
        end
        else if (wr8[gi])
        begin
          cnt8_reg[gi] <= wbyte;
          lat8_reg[gi] <= wbyte;
        end
        else if (uf8[gi])
          cnt8_reg[gi] <= lat8_reg[gi];
        else if (en8[gi])
          cnt8_reg[gi] <= cnt8_reg[gi] - 8'h01;
      end
    end
  endgenerate

  // Two 16-bit reload counters with paired byte access.
  // A low write is held until the high write commits all 16 bits.
  logic [15:0] cnt16_reg [2];
  logic [15:0] lat16_reg [2];
  logic [7:0]  low_hold_reg [2];
  logic [7:0]  low_snap_reg [2];
  wire  [1:0]  en16;
  wire  [1:0]  uf16;
  wire  [1:0]  wr_low  = {hit_bl, hit_al} & {2{wr_acc}};
  wire  [1:0]  wr_high = {hit_bh, hit_ah} & {2{wr_acc}};
  wire  [1:0]  rd_high = {hit_bh, hit_ah} & {2{rd_acc}};
  wire  [2:0]  sel_a   = src_sel_reg[QRT_SRC_A_LSB +: 3];
  wire  [2:0]  sel_b   = src_sel_reg[QRT_SRC_B_LSB +: 3];

  assign en16[0] = (sel_a >= QRT_SRC_ALT) ? ring_rise
                                          : div_tick[sel_a];
  assign en16[1] = (sel_b >= QRT_SRC_ALT) ? uf16[0]
                                          : div_tick[sel_b];

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_wide
      wire commit_cnt = wr_high[gi] & ~wide_ctrl_reg[gi];
      assign uf16[gi] = en16[gi] & ~commit_cnt
                      & (cnt16_reg[gi] == QRT_RST_WORD);
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          cnt16_reg[gi]    <= QRT_RST_WORD;
          lat16_reg[gi]    <= QRT_RST_WORD;
          low_hold_reg[gi] <= QRT_RST_BYTE;
          low_snap_reg[gi] <= QRT_RST_BYTE;
        end
        else
        begin
          if (wr_low[gi])
            low_hold_reg[gi] <= wbyte;
          if (wr_high[gi])
            lat16_reg[gi] <= {wbyte, low_hold_reg[gi]};
          if (rd_high[gi])
            low_snap_reg[gi] <= cnt16_reg[gi][7:0];
          if (commit_cnt)
            cnt16_reg[gi] <= {wbyte, low_hold_reg[gi]};
          else if (uf16[gi])
            cnt16_reg[gi] <= lat16_reg[gi];
          else if (en16[gi])
            cnt16_reg[gi] <= cnt16_reg[gi] - 16'h0001;
        end
      end
    end
  endgenerate

  // Pulse output and event pin drive.
  // A control write restarts the pulse level from the polarity bit.
  logic pulse_reg;
  logic oe_n_reg;
  logic inv_reg;
  wire  mode_wr = wr_acc & hit_mode;
  wire  new_pol = wbyte[QRT_MM_POL_BIT];
  wire  pulse_next = mode_wr ? ~new_pol
                   : ((mm_mode == QRT_MODE_PULSE) & uf8[3]) ? ~pulse_reg
                   : pulse_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pulse_reg <= 1'b1;
      oe_n_reg  <= 1'b1;
      inv_reg   <= 1'b0;
    end
    else
    begin
      pulse_reg <= pulse_next;
      oe_n_reg  <= mm_mode != QRT_MODE_PULSE;
      inv_reg   <= mm_inv_en & ~pulse_next;
    end
  end

  // Request flags: set wins over a same-cycle clear by write of one.
  logic [QRT_REQ_W-1:0] flags_reg;
  wire  [QRT_REQ_W-1:0] flag_set;
  wire  [QRT_REQ_W-1:0] flag_clr = (wr_acc & hit_flags)
                                 ? wbyte[QRT_REQ_W-1:0] : 5'h00;

  assign flag_set[QRT_REQ_FIXED] = uf8[1];
  assign flag_set[QRT_REQ_MM]    = uf8[3];
  assign flag_set[QRT_REQ_WA]    = uf16[0];
  assign flag_set[QRT_REQ_WB]    = uf16[1];
  assign flag_set[QRT_REQ_EVT]   = mm_pol ? evt_rise : evt_fall;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      flags_reg <= 5'h00;
    else
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
  end

  // Read data selection.
  wire [7:0] rd_byte =
      hit_clk   ? clk_mode_reg
    : hit_fpre  ? cnt8_reg[0]
    : hit_fcnt  ? cnt8_reg[1]
    : hit_mpre  ? cnt8_reg[2]
    : hit_mcnt  ? cnt8_reg[3]
    : hit_mode  ? mm_mode_reg
    : hit_ah    ? cnt16_reg[0][15:8]
    : hit_al    ? low_snap_reg[0]
    : hit_bh    ? cnt16_reg[1][15:8]
    : hit_bl    ? low_snap_reg[1]
    : hit_src   ? {2'b00, src_sel_reg}
    : hit_wctl  ? {6'h00, wide_ctrl_reg}
    : hit_flags ? {3'b000, flags_reg}
    : QRT_RST_BYTE;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= QRT_RST_DATA;
    end
    else
    begin
      pready_reg  <= acc_first;
      pslverr_reg <= acc_first & ~hit_any;
      if (acc_first & ~pwrite)
        prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign event_pin_out      = pulse_reg;
  assign event_pin_oe_n     = oe_n_reg;
  assign inverted_pulse_pin = inv_reg;
  assign req_flags          = flags_reg;
endmodule

// ---- test/qrt_checker.sv ----
// Concurrent checks on the ports of the quad reload timer unit.
`timescale 1ns/1ps
module qrt_checker
(
  // Clock and reset.
  input wire logic        clock,
  input wire logic        sys_rst,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and flags.
  input wire logic        event_pin_out,
  input wire logic        event_pin_oe_n,
  input wire logic        inverted_pulse_pin,
  input wire logic [4:0]  req_flags
);
  import qrt_pkg::*;
  logic wr_done;
  logic clr_done;
  assign wr_done  = psel && penable && pready && pwrite;
  assign clr_done = wr_done && (paddr == QRT_OFF_REQ_FLAGS);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  ready_wait_a: assert property (s_setup ##1 s_wait |=> pready)
    else $error("pready late after access start");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  unmapped_err_a: assert property (
    pready && !pwrite && paddr > QRT_OFF_REQ_FLAGS |-> pslverr && !(|prdata))
    else $error("unmapped read not refused");
  read_width_a: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  flag_sticky_a: assert property (
    |($past(req_flags) & ~req_flags) |-> $past(clr_done) || $past(clr_done, 2))
    else $error("request flag fell without a clear");
  pulse_toggle_a: assert property (
    $changed(event_pin_out) |-> !event_pin_oe_n || $past(wr_done)
      || $past(wr_done, 2))
    else $error("pulse output moved while not driving");
  inv_comp_a: assert property (inverted_pulse_pin |-> !event_pin_out)
    else $error("secondary pin not the complement");
  oe_by_write_a: assert property (
    $changed(event_pin_oe_n) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("pin drive changed without a mode write");
endmodule

bind qrt_top qrt_checker u_chk
(
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .event_pin_out(event_pin_out),
  .event_pin_oe_n(event_pin_oe_n), .inverted_pulse_pin(inverted_pulse_pin),
  .req_flags(req_flags)
);

// ---- test/qrt_far_side.sv ----
// Far-side model: oscillator pins and the external event pin source.
`timescale 1ns/1ps
module qrt_far_side
(
  // Clock.
  input  wire logic clock,
  // Pins.
  input  wire logic event_pin_out,
  input  wire logic event_pin_oe_n,
  output logic      main_osc_input,
  output logic      ring_osc_input,
  output wire logic event_pin_in
);
  logic ext_level;
  initial
  begin
    main_osc_input = 1'b0;
    ring_osc_input = 1'b0;
    ext_level      = 1'b0;
  end
  // The wire follows the unit while it drives, else the outside source.
  assign event_pin_in = event_pin_oe_n ? ext_level : event_pin_out;
  // Each level is held several clocks so the synchroniser sees it.
  task automatic osc(input bit ring, input int n);
    repeat (n)
    begin
      @(posedge clock);
      ring_osc_input <= ring;
      main_osc_input <= !ring;
      repeat (3) @(posedge clock);
      ring_osc_input <= 1'b0;
      main_osc_input <= 1'b0;
      repeat (2) @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask
  task automatic level(input logic v);
    @(posedge clock);
    ext_level <= v;
    repeat (8) @(posedge clock);
  endtask
endmodule

// ---- test/tb_quad_reload_timer_unit.sv ----
// Self-checking bench for the quad reload timer unit.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[ERR] %0t got %h expected %h", $time, g, e); \
    end \
  end
module tb_quad_reload_timer_unit;
  import qrt_pkg::*;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        main_osc, ring_osc, evt_in, evt_out, evt_oe_n, inv_pin;
  logic        rerr;
  logic [4:0]  req_flags;
  int          err_count, num_checks, cycles;
  qrt_top u_qrt_top
  (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_osc_input(main_osc),
    .ring_osc_input(ring_osc), .event_pin_in(evt_in),
    .event_pin_out(evt_out), .event_pin_oe_n(evt_oe_n),
    .inverted_pulse_pin(inv_pin), .req_flags(req_flags)
  );
  qrt_far_side u_qrt_far_side
  (
    .clock(clock), .event_pin_out(evt_out), .event_pin_oe_n(evt_oe_n),
    .main_osc_input(main_osc), .ring_osc_input(ring_osc),
    .event_pin_in(evt_in)
  );
  always #2.5 clock = ~clock;
  task automatic finish_test;
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      err_count++;
      finish_test;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdat, {24'h00_0000, e})
  endtask
  task automatic ring(input int n);
    u_qrt_far_side.osc(1'b1, n);
  endtask
  task automatic clr;
    wr(QRT_OFF_REQ_FLAGS, 8'h1F);
  endtask
  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, num_checks} = '0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    `CHK({evt_out, evt_oe_n, req_flags}, 7'h60)
    for (int i = 0; i < 13; i++)
      rd(12'(4 * i), 8'h00);
    apb(1'b1, 12'h100, 32'h0000_00FF);
    `CHK(rerr, 1'b1)
    apb(1'b0, 12'h100, 32'h0000_0000);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    // Fixed pair: load, read back, divider source choice.
    wr(QRT_OFF_FIXED_PRE, 8'h5A);
    wr(QRT_OFF_FIXED_CNT, 8'h33);
    rd(QRT_OFF_FIXED_PRE, 8'h5A);
    rd(QRT_OFF_FIXED_CNT, 8'h33);
    ring(16);
    rd(QRT_OFF_FIXED_PRE, 8'h5A);
    u_qrt_far_side.osc(1'b0, 16);
    rd(QRT_OFF_FIXED_PRE, 8'h59);
    wr(QRT_OFF_CLK_MODE, 8'h80);
    u_qrt_far_side.osc(1'b0, 16);
    rd(QRT_OFF_FIXED_PRE, 8'h59);
    ring(16);
    rd(QRT_OFF_FIXED_PRE, 8'h58);
    // Multimode timer mode on the ring source, then stop.
    wr(QRT_OFF_MM_MODE, 8'h68);
    wr(QRT_OFF_MM_PRE, 8'h01);
    wr(QRT_OFF_MM_CNT, 8'h02);
    wr(QRT_OFF_MM_MODE, 8'h60);
    clr();
    ring(1);
    rd(QRT_OFF_MM_PRE, 8'h00);
    ring(1);
    rd(QRT_OFF_MM_CNT, 8'h01);
    ring(3);
    `CHK(req_flags[QRT_REQ_MM], 1'b0)
    ring(1);
    `CHK(req_flags[QRT_REQ_MM], 1'b1)
    rd(QRT_OFF_MM_CNT, 8'h02);
    wr(QRT_OFF_MM_MODE, 8'h68);
    ring(4);
    rd(QRT_OFF_MM_CNT, 8'h02);
    rd(QRT_OFF_MM_PRE, 8'h01);
    // Pulse output mode and its complement.
    wr(QRT_OFF_MM_PRE, 8'h00);
    wr(QRT_OFF_MM_CNT, 8'h00);
    wr(QRT_OFF_MM_MODE, 8'h71);
    repeat (3) @(posedge clock);
    `CHK({evt_out, evt_oe_n, inv_pin}, 3'b100)
    ring(1);
    `CHK({evt_out, inv_pin}, 2'b01)
    ring(1);
    `CHK({evt_out, inv_pin}, 2'b10)
    wr(QRT_OFF_MM_MODE, 8'h75);
    repeat (3) @(posedge clock);
    `CHK({evt_out, inv_pin}, 2'b01)
    // Event count mode, both polarities.
    wr(QRT_OFF_MM_MODE, 8'h0A);
    wr(QRT_OFF_MM_CNT, 8'h03);
    wr(QRT_OFF_MM_MODE, 8'h02);
    clr();
    u_qrt_far_side.level(1'b1);
    rd(QRT_OFF_MM_CNT, 8'h02);
    `CHK(req_flags[QRT_REQ_EVT], 1'b0)
    u_qrt_far_side.level(1'b0);
    rd(QRT_OFF_MM_CNT, 8'h02);
    `CHK(req_flags[QRT_REQ_EVT], 1'b1)
    wr(QRT_OFF_MM_MODE, 8'h06);
    clr();
    u_qrt_far_side.level(1'b1);
    `CHK(req_flags[QRT_REQ_EVT], 1'b1)
    u_qrt_far_side.level(1'b0);
    rd(QRT_OFF_MM_CNT, 8'h01);
    // Width measurement counts only while the pin is high.
    wr(QRT_OFF_MM_MODE, 8'h6B);
    wr(QRT_OFF_MM_CNT, 8'h09);
    wr(QRT_OFF_MM_MODE, 8'h63);
    ring(2);
    rd(QRT_OFF_MM_CNT, 8'h09);
    u_qrt_far_side.level(1'b1);
    ring(2);
    rd(QRT_OFF_MM_CNT, 8'h07);
    // Wide counters: A on ring, B on A underflow.
    wr(QRT_OFF_MM_MODE, 8'h08);
    wr(QRT_OFF_SRC_SEL, 8'h36);
    wr(QRT_OFF_WIDE_CTRL, 8'h00);
    wr(QRT_OFF_WIDE_A_LOW, 8'h02);
    wr(QRT_OFF_WIDE_A_HIGH, 8'h00);
    wr(QRT_OFF_WIDE_B_LOW, 8'h01);
    wr(QRT_OFF_WIDE_B_HIGH, 8'h00);
    clr();
    rd(QRT_OFF_WIDE_A_HIGH, 8'h00);
    rd(QRT_OFF_WIDE_A_LOW, 8'h02);
    ring(3);
    `CHK(req_flags[3:2], 2'b01)
    rd(QRT_OFF_WIDE_A_HIGH, 8'h00);
    rd(QRT_OFF_WIDE_A_LOW, 8'h02);
    ring(3);
    `CHK(req_flags[QRT_REQ_WB], 1'b1)
    wr(QRT_OFF_WIDE_CTRL, 8'h01);
    wr(QRT_OFF_WIDE_A_LOW, 8'h05);
    wr(QRT_OFF_WIDE_A_HIGH, 8'h01);
    rd(QRT_OFF_WIDE_A_HIGH, 8'h00);
    rd(QRT_OFF_WIDE_A_LOW, 8'h02);
    ring(3);
    rd(QRT_OFF_WIDE_A_HIGH, 8'h01);
    rd(QRT_OFF_WIDE_A_LOW, 8'h05);
    // Main oscillator over two for the multimode and wide A counters.
    wr(QRT_OFF_MM_PRE, 8'h05);
    wr(QRT_OFF_MM_MODE, 8'h00);
    wr(QRT_OFF_CLK_MODE, 8'h00);
    wr(QRT_OFF_SRC_SEL, 8'h30);
    wr(QRT_OFF_WIDE_CTRL, 8'h00);
    wr(QRT_OFF_WIDE_A_LOW, 8'h05);
    wr(QRT_OFF_WIDE_A_HIGH, 8'h00);
    u_qrt_far_side.osc(1'b0, 4);
    rd(QRT_OFF_MM_PRE, 8'h03);
    rd(QRT_OFF_WIDE_A_HIGH, 8'h00);
    rd(QRT_OFF_WIDE_A_LOW, 8'h03);
    finish_test;
  end
endmodule
